/* File: hdl/bscc_unit.sv */
// bit search, decode, ones count, toggle and type conversion unit
// Summary of operation
// - search upward from start; result is distance to first set bit
// - no set bit in span stores 65535
// - search length 1 to 256 within operand range, else error flag
// - search runs across word boundaries with one continuous offset
// - decode adds offset to base bit and sets that bit
// - offset 0 to 255 and target in range, else error flag
// - ones count over consecutive bits stored to destination
// - count quantity 1 to 256 within range, else error flag
// - timer source gives current value; destination gets preset 0 to 65535
// - special relays refused as destination; relays up to 2557 writable by decode and toggle, word writes end at relay 2543
// - operations execute again on every scan while enabled
// - toggle sets bit, holds it after enable drops, next activation clears
// - toggle inverts on every scan while enable stays on
// - word and integer one location; double, long, float two locations
// - same source and destination type copies data unchanged
// - unless both float, only integer part is transferred
// - out of range source saturates to nearest destination value
// - repeat count 1 to 99 processes consecutive elements
// - float allows data or constant source, data destination only
// - non-normal float operand raises error flag and indicator
`timescale 1ns/1ps
`default_nettype none
module bscc_unit (
  // clock, reset, enable
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ce,
  // instruction issue
  input  wire logic                 i_req_valid,
  input  wire logic                 i_rung_en,
  input  wire bscc_pkg::bscc_req_t  i_req,
  input  wire logic                 i_err_clr,
  // host access to operands
  input  wire bscc_pkg::bscc_host_t i_host,
  output logic [15:0]               o_host_rdata,
  // status
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_program_execution_error_flag,
  output logic                      o_err_led
);
  logic [15:0] mem [0:bscc_pkg::MEM_WORDS-1];
  logic [15:0] tc_cur [0:15];
  logic [15:0] tc_pre [0:15];

  bscc_pkg::bscc_st_t  st_r, st_nxt;
  bscc_pkg::bscc_req_t rq_r;
  logic [8:0]  idx_r;
  logic [8:0]  acc_r;
  logic [11:0] sa_r, da_r;
  logic        take, fin, err_set, res_en;
  logic [15:0] res;
  logic        w0_en, w1_en, b_en, tp_en, b_v, b_old, bit_cur, last;
  logic [7:0]  w0_a, w1_a;
  logic [15:0] w0_d, w1_d, tp_d, ofs;
  logic [11:0] b_a;
  logic [3:0]  tp_a;
  logic [12:0] tgt;
  logic        walk_ok, dec_ok, tgl_ok, cvt_ok, any_f;
  logic [31:0] sval;
  logic [32:0] cv;
  bscc_pkg::bscc_ty_t dt_eff;

  function automatic logic [12:0] f_ext(input bscc_pkg::bscc_area_t a);
    unique case (a)
      bscc_pkg::AR_RELAY: f_ext = bscc_pkg::RELAY_BITS;
      bscc_pkg::AR_DATA:  f_ext = bscc_pkg::DATA_BITS;
      bscc_pkg::AR_TC:    f_ext = bscc_pkg::TC_COUNT;
      default:            f_ext = 13'h0000;
    endcase
  endfunction

  function automatic logic [11:0] f_base(input bscc_pkg::bscc_area_t a);
    f_base = (a == bscc_pkg::AR_DATA) ? bscc_pkg::DATA_BASE : 12'h000;
  endfunction

  function automatic logic f_bit(input logic [11:0] b);
    f_bit = mem[b[11:4]][b[3:0]];
  endfunction

  // word read; timers give their current value
  function automatic logic [15:0] f_rdw(input bscc_pkg::bscc_area_t a,
                                        input logic [11:0] ad, input logic [15:0] k);
    logic [11:0] e;
    e = f_base(a) + ad;
    unique case (a)
      bscc_pkg::AR_CONST: f_rdw = k;
      bscc_pkg::AR_TC:    f_rdw = tc_cur[ad[3:0]];
      default:            f_rdw = mem[e[11:4]];
    endcase
  endfunction

  // n words aligned and inside the area; relay writes stop at the last ordinary relay
  function automatic logic f_wok(input bscc_pkg::bscc_area_t a, input logic [11:0] ad,
                                 input logic [12:0] n, input logic d);
    logic [12:0] lim, span;
    lim  = (d && a == bscc_pkg::AR_RELAY) ? bscc_pkg::RELAY_WR_END : f_ext(a);
    span = (a == bscc_pkg::AR_TC) ? n : 13'(n << 4);
    f_wok = (a == bscc_pkg::AR_TC || ad[3:0] == 4'h0) && n != 13'h0000 &&
            ({1'b0, ad} + span <= lim);
  endfunction

  function automatic logic [12:0] f_sz(input bscc_pkg::bscc_ty_t t);
    f_sz = (t == bscc_pkg::TY_W || t == bscc_pkg::TY_I) ? 13'h0001 : 13'h0002;
  endfunction

  function automatic logic signed [40:0] f_clamp(input logic signed [40:0] n,
                                                 input logic signed [40:0] lo,
                                                 input logic signed [40:0] hi);
    f_clamp = (n < lo) ? lo : ((n > hi) ? hi : n);
  endfunction

  // returns {not normal, result}
  function automatic logic [32:0] f_cvt(input logic [31:0] v, input bscc_pkg::bscc_ty_t st,
                                        input bscc_pkg::bscc_ty_t dt);
    logic signed [40:0] n;
    logic [40:0] mg;
    logic [7:0]  e;
    logic [5:0]  p;
    logic        bad;
    logic [31:0] r;
    e = v[30:23];
    bad = 1'b0;
    mg = '0;
    p = '0;
    r = v;
    unique case (st)
      bscc_pkg::TY_W: n = 41'(v[15:0]);
      bscc_pkg::TY_I: n = 41'($signed(v[15:0]));
      bscc_pkg::TY_D: n = 41'(v);
      bscc_pkg::TY_L: n = 41'($signed(v));
      default: begin
        bad = (e == 8'hFF) || (e == 8'h00 && v[22:0] != 23'h000000);
        mg = {17'h00000, 1'b1, v[22:0]};
        if (e < bscc_pkg::F_BIAS) begin
          mg = '0;
        end else if (e > bscc_pkg::F_BIG) begin
          mg = {1'b0, {40{1'b1}}};
        end else if (e >= bscc_pkg::F_UNIT) begin
          mg = mg << (e - bscc_pkg::F_UNIT);
        end else begin
          mg = mg >> (bscc_pkg::F_UNIT - e);
        end
        n = v[31] ? -$signed(mg) : $signed(mg);
      end
    endcase
    unique case (dt)
      bscc_pkg::TY_W: r = 32'(f_clamp(n, 41'sh0, 41'sh0FFFF));
      bscc_pkg::TY_I: r = 32'(f_clamp(n, -41'sh08000, 41'sh07FFF));
      bscc_pkg::TY_D: r = 32'(f_clamp(n, 41'sh0, 41'sh0FFFFFFFF));
      bscc_pkg::TY_L: r = 32'(f_clamp(n, -41'sh080000000, 41'sh07FFFFFFF));
      default: begin
        mg = n[40] ? 41'(-n) : 41'(n);
        for (int i = 0; i < 41; i++) begin
          if (mg[i]) p = 6'(i);
        end
        mg = mg << (6'd40 - p);
        r = (n == 41'sh0) ? 32'h00000000 : {n[40], 8'(bscc_pkg::F_BIAS + 8'(p)), mg[39:17]};
      end
    endcase
    if (st == dt) r = v;
    f_cvt = {bad, r};
  endfunction

  assign take = (st_r == bscc_pkg::ST_IDLE) && i_req_valid;

  // issue checks
  always_comb begin
    ofs = f_rdw(i_req.src_area, i_req.src_addr, i_req.konst[15:0]);
    tgt = {1'b0, i_req.dst_addr} + {4'h0, ofs[8:0]};
    any_f = (i_req.src_type == bscc_pkg::TY_F) || (i_req.dst_type == bscc_pkg::TY_F);
    walk_ok = i_req.len != 16'h0000 && i_req.len <= bscc_pkg::LEN_MAX &&
              (i_req.src_area == bscc_pkg::AR_RELAY || i_req.src_area == bscc_pkg::AR_DATA) &&
              ({1'b0, i_req.src_addr} + i_req.len[12:0] <= f_ext(i_req.src_area)) &&
              f_wok(i_req.dst_area, i_req.dst_addr, 13'h0001, 1'b1);
    dec_ok = (i_req.src_area == bscc_pkg::AR_CONST ||
              f_wok(i_req.src_area, i_req.src_addr, 13'h0001, 1'b0)) &&
             ofs <= bscc_pkg::OFS_MAX &&
             (i_req.dst_area == bscc_pkg::AR_RELAY || i_req.dst_area == bscc_pkg::AR_DATA) &&
             tgt < ((i_req.dst_area == bscc_pkg::AR_RELAY) ?
                    bscc_pkg::RELAY_WR_END : bscc_pkg::DATA_BITS);
    tgl_ok = i_req.dst_area == bscc_pkg::AR_RELAY &&
             {1'b0, i_req.dst_addr} < bscc_pkg::RELAY_WR_END;
    cvt_ok = i_req.len != 16'h0000 && i_req.len <= bscc_pkg::REP_MAX &&
             (i_req.src_area == bscc_pkg::AR_CONST ||
              f_wok(i_req.src_area, i_req.src_addr,
                    13'(i_req.len[6:0] * f_sz(i_req.src_type)), 1'b0)) &&
             f_wok(i_req.dst_area, i_req.dst_addr,
                   (i_req.dst_area == bscc_pkg::AR_TC) ? 13'(i_req.len[6:0]) :
                   13'(i_req.len[6:0] * f_sz(i_req.dst_type)), 1'b1) &&
             (!any_f || ((i_req.src_area == bscc_pkg::AR_DATA ||
                          i_req.src_area == bscc_pkg::AR_CONST) &&
                         i_req.dst_area == bscc_pkg::AR_DATA));
  end

  // element fetch and conversion
  always_comb begin
    logic [11:0] s1;
    s1 = sa_r + ((rq_r.src_area == bscc_pkg::AR_TC) ? 12'h001 : 12'h010);
    if (f_sz(rq_r.src_type) == 13'h0002) begin
      sval = {f_rdw(rq_r.src_area, sa_r, rq_r.konst[31:16]),
              f_rdw(rq_r.src_area, s1, rq_r.konst[15:0])};
    end else begin
      sval = {16'h0000, f_rdw(rq_r.src_area, sa_r, rq_r.konst[15:0])};
    end
    dt_eff = (rq_r.dst_area == bscc_pkg::AR_TC) ? bscc_pkg::TY_W : rq_r.dst_type;
    cv = f_cvt(sval, rq_r.src_type, dt_eff);
  end

  assign bit_cur = f_bit(f_base(rq_r.src_area) + rq_r.src_addr + {3'h0, idx_r});
  assign last = {7'h00, idx_r} == rq_r.len - 16'h0001;
  assign b_old = f_bit(b_a);

  always_comb begin
    logic [11:0] dw;
    st_nxt = st_r;
    fin = 1'b0;
    err_set = 1'b0;
    res_en = 1'b0;
    res = '0;
    w0_en = 1'b0;
    w1_en = 1'b0;
    w0_a = '0;
    w1_a = '0;
    w0_d = '0;
    w1_d = '0;
    b_en = 1'b0;
    b_a = '0;
    b_v = 1'b0;
    tp_en = 1'b0;
    tp_a = '0;
    tp_d = '0;
    dw = '0;
    unique case (st_r)
      bscc_pkg::ST_IDLE: begin
        if (take && !i_rung_en) begin
          fin = 1'b1;
        end else if (take) begin
          unique case (i_req.op)
            bscc_pkg::OP_ENC, bscc_pkg::OP_CNT: begin
              if (walk_ok) st_nxt = bscc_pkg::ST_WALK;
              else err_set = 1'b1;
              fin = !walk_ok;
            end
            bscc_pkg::OP_DEC: begin
              b_a = f_base(i_req.dst_area) + tgt[11:0];
              b_en = dec_ok;
              b_v = 1'b1;
              err_set = !dec_ok;
              fin = 1'b1;
            end
            bscc_pkg::OP_TGL: begin
              b_a = i_req.dst_addr;
              b_en = tgl_ok;
              b_v = !b_old;
              err_set = !tgl_ok;
              fin = 1'b1;
            end
            bscc_pkg::OP_CVT: begin
              if (cvt_ok) st_nxt = bscc_pkg::ST_CONV;
              else err_set = 1'b1;
              fin = !cvt_ok;
            end
            default: begin
              err_set = 1'b1;
              fin = 1'b1;
            end
          endcase
        end
      end
      bscc_pkg::ST_WALK: begin
        if (rq_r.op == bscc_pkg::OP_ENC && bit_cur) begin
          res = {7'h00, idx_r};
          res_en = 1'b1;
        end else if (last) begin
          res = (rq_r.op == bscc_pkg::OP_ENC) ? bscc_pkg::NOT_FOUND :
                16'(acc_r + {8'h00, bit_cur});
          res_en = 1'b1;
        end
        fin = res_en;
      end
      bscc_pkg::ST_CONV: begin
        dw = f_base(rq_r.dst_area) + da_r;
        if (cv[32]) begin
          err_set = 1'b1;
          fin = 1'b1;
        end else begin
          fin = last;
          if (rq_r.dst_area == bscc_pkg::AR_TC) begin
            tp_en = 1'b1;
            tp_a = da_r[3:0];
            tp_d = cv[15:0];
          end else if (f_sz(rq_r.dst_type) == 13'h0002) begin
            w0_en = 1'b1;
            w0_a = dw[11:4];
            w0_d = cv[31:16];
            w1_en = 1'b1;
            w1_a = dw[11:4] + 8'h01;
            w1_d = cv[15:0];
          end else begin
            w0_en = 1'b1;
            w0_a = dw[11:4];
            w0_d = cv[15:0];
          end
        end
      end
      default: st_nxt = bscc_pkg::ST_IDLE;
    endcase
    if (fin) st_nxt = bscc_pkg::ST_IDLE;
    if (res_en) begin
      dw = f_base(rq_r.dst_area) + rq_r.dst_addr;
      tp_en = rq_r.dst_area == bscc_pkg::AR_TC;
      tp_a = rq_r.dst_addr[3:0];
      tp_d = res;
      w0_en = !tp_en;
      w0_a = dw[11:4];
      w0_d = res;
    end
  end

  // sequencing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= bscc_pkg::ST_IDLE;
      rq_r <= '0;
      idx_r <= '0;
      acc_r <= '0;
      sa_r <= '0;
      da_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      if (take) begin
        rq_r <= i_req;
        idx_r <= '0;
        acc_r <= '0;
        sa_r <= i_req.src_addr;
        da_r <= i_req.dst_addr;
      end else if (st_r != bscc_pkg::ST_IDLE) begin
        idx_r <= idx_r + 9'h001;
        acc_r <= acc_r + {8'h00, bit_cur};
        if (rq_r.src_area != bscc_pkg::AR_CONST) begin
          sa_r <= sa_r + ((rq_r.src_area == bscc_pkg::AR_TC) ?
                  12'(f_sz(rq_r.src_type)) : 12'(f_sz(rq_r.src_type) << 4));
        end
        da_r <= da_r + ((rq_r.dst_area == bscc_pkg::AR_TC) ? 12'h001 :
                12'(f_sz(rq_r.dst_type) << 4));
      end
    end
  end

  // operand storage; the unit's own writes win over the host
  always_ff @(posedge i_sys_clk) begin
    if (i_ce) begin
      if (i_host.we && !i_host.tc) mem[i_host.addr] <= i_host.data;
      if (i_host.we && i_host.tc) tc_cur[i_host.addr[3:0]] <= i_host.data;
      if (w0_en) mem[w0_a] <= w0_d;
      if (w1_en) mem[w1_a] <= w1_d;
      if (b_en) mem[b_a[11:4]][b_a[3:0]] <= b_v;
      if (tp_en) tc_pre[tp_a] <= tp_d;
    end
  end

  // status outputs; a new error beats a clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_program_execution_error_flag <= 1'b0;
      o_err_led <= 1'b0;
      o_host_rdata <= '0;
    end else if (i_ce) begin
      o_busy <= st_nxt != bscc_pkg::ST_IDLE;
      o_done <= fin;
      o_program_execution_error_flag <= err_set | (o_program_execution_error_flag & !i_err_clr);
      o_err_led <= err_set | (o_program_execution_error_flag & !i_err_clr);
      o_host_rdata <= i_host.tc ? tc_pre[i_host.addr[3:0]] : mem[i_host.addr];
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);

  enc_hit_a: assert property (
    st_r == bscc_pkg::ST_WALK && rq_r.op == bscc_pkg::OP_ENC && bit_cur
    |-> res_en && res == {7'h00, idx_r} ##1 o_done) else $error("encode offset wrong");
  enc_miss_a: assert property (
    st_r == bscc_pkg::ST_WALK && rq_r.op == bscc_pkg::OP_ENC && last && !bit_cur
    |-> res == bscc_pkg::NOT_FOUND) else $error("encode miss not 65535");
  enc_len_a: assert property (
    take && i_rung_en && i_req.op == bscc_pkg::OP_ENC && i_req.len > bscc_pkg::LEN_MAX
    |=> o_program_execution_error_flag && o_done) else $error("encode length unchecked");
  walk_pos_a: assert property (
    st_r == bscc_pkg::ST_WALK |-> {7'h00, idx_r} < rq_r.len) else $error("walk overran");
  dec_set_a: assert property (
    take && i_rung_en && i_req.op == bscc_pkg::OP_DEC && dec_ok
    |=> f_bit($past(b_a))) else $error("decode bit not set");
  dec_ofs_a: assert property (
    take && i_rung_en && i_req.op == bscc_pkg::OP_DEC && ofs > bscc_pkg::OFS_MAX
    |-> !b_en ##1 o_program_execution_error_flag) else $error("decode offset unchecked");
  cnt_bound_a: assert property (
    st_r == bscc_pkg::ST_WALK && rq_r.op == bscc_pkg::OP_CNT |-> acc_r <= idx_r)
    else $error("count exceeds bits seen");
  spec_dst_a: assert property (
    take && i_rung_en && i_req.dst_area == bscc_pkg::AR_SPEC
    |=> o_program_execution_error_flag && !o_busy) else $error("special relay written");
  no_en_a: assert property (
    take && !i_rung_en |-> !b_en && !w0_en ##1 o_done) else $error("disabled op acted");
  tgl_inv_a: assert property (
    take && i_rung_en && i_req.op == bscc_pkg::OP_TGL && tgl_ok
    |=> f_bit($past(b_a)) != $past(b_old)) else $error("toggle did not invert");
  flt_area_a: assert property (
    take && i_rung_en && i_req.op == bscc_pkg::OP_CVT && any_f &&
    i_req.dst_area != bscc_pkg::AR_DATA |=> o_program_execution_error_flag)
    else $error("float destination unchecked");
  fin_done_a: assert property (
    fin |=> o_done && !o_busy) else $error("finish not reported");

  enc_hit_c: cover property (st_r == bscc_pkg::ST_WALK && rq_r.op == bscc_pkg::OP_ENC && bit_cur);
  cvt_rep_c: cover property (st_r == bscc_pkg::ST_CONV && idx_r == 9'h002 && fin);
  tgl_c: cover property (b_en && st_r == bscc_pkg::ST_IDLE && rq_r.op == bscc_pkg::OP_TGL);
endmodule // bscc_unit
`default_nettype wire

/* File: inc/bscc_pkg.sv */
// constants and types of the bit search, count and convert unit
`default_nettype none
package bscc_pkg;
  localparam int unsigned MEM_WORDS = 256;
  localparam logic [12:0] RELAY_BITS   = 13'h0A00;
  localparam logic [12:0] RELAY_WR_END = 13'h09FE;
  localparam logic [12:0] DATA_BITS    = 13'h0600;
  localparam logic [11:0] DATA_BASE    = 12'hA00;
  localparam logic [12:0] TC_COUNT     = 13'h0010;
  localparam logic [15:0] NOT_FOUND    = 16'hFFFF;
  localparam logic [15:0] LEN_MAX      = 16'h0100;
  localparam logic [15:0] OFS_MAX      = 16'h00FF;
  localparam logic [15:0] REP_MAX      = 16'h0063;
  localparam logic [7:0]  F_BIAS       = 8'h7F;
  localparam logic [7:0]  F_UNIT       = 8'h96;
  localparam logic [7:0]  F_BIG        = 8'hA4;

  typedef enum logic [2:0] {
    OP_ENC = 3'h0, OP_DEC = 3'h1, OP_CNT = 3'h2, OP_TGL = 3'h3, OP_CVT = 3'h4
  } bscc_op_t;

  typedef enum logic [2:0] {
    AR_RELAY = 3'h0, AR_DATA = 3'h1, AR_SPEC = 3'h2, AR_TC = 3'h3, AR_CONST = 3'h4
  } bscc_area_t;

  typedef enum logic [2:0] {
    TY_W = 3'h0, TY_I = 3'h1, TY_D = 3'h2, TY_L = 3'h3, TY_F = 3'h4
  } bscc_ty_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_WALK = 3'h2, ST_CONV = 3'h4
  } bscc_st_t;

  typedef struct packed {
    bscc_op_t    op;
    bscc_area_t  src_area;
    logic [11:0] src_addr;
    bscc_area_t  dst_area;
    logic [11:0] dst_addr;
    bscc_ty_t    src_type;
    bscc_ty_t    dst_type;
    logic [15:0] len;
    logic [31:0] konst;
  } bscc_req_t;

  typedef struct packed {
    logic        we;
    logic        tc;
    logic [7:0]  addr;
    logic [15:0] data;
  } bscc_host_t;
endpackage
`default_nettype wire

/* File: dv/bscc_unit_tb.sv */
// self-checking bench for the bit search, count and convert unit
`timescale 1ns/1ps
`default_nettype none
module bscc_unit_tb;
  localparam bscc_pkg::bscc_area_t RL = bscc_pkg::AR_RELAY;
  localparam bscc_pkg::bscc_area_t DA = bscc_pkg::AR_DATA;
  localparam bscc_pkg::bscc_area_t KC = bscc_pkg::AR_CONST;
  localparam bscc_pkg::bscc_ty_t   TW = bscc_pkg::TY_W;
  localparam bscc_pkg::bscc_ty_t   TF = bscc_pkg::TY_F;
  localparam bscc_pkg::bscc_ty_t   TD = bscc_pkg::TY_D;
  logic                 i_sys_clk;
  logic                 i_rst_n;
  logic                 i_ce;
  logic                 i_req_valid;
  logic                 i_rung_en;
  bscc_pkg::bscc_req_t  i_req;
  logic                 i_err_clr;
  bscc_pkg::bscc_host_t i_host;
  logic [15:0]          o_host_rdata;
  logic                 o_busy;
  logic                 o_done;
  logic                 o_program_execution_error_flag;
  logic                 o_err_led;
  logic [15:0]          mdl [256];
  logic [15:0]          rv;
  bscc_pkg::bscc_req_t  q [$];
  int                   err_count;
  int                   checked;
  int                   s;
  int                   t;

  bscc_unit uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_req_valid(i_req_valid), .i_rung_en(i_rung_en), .i_req(i_req),
    .i_err_clr(i_err_clr), .i_host(i_host), .o_host_rdata(o_host_rdata),
    .o_busy(o_busy), .o_done(o_done), .o_err_led(o_err_led),
    .o_program_execution_error_flag(o_program_execution_error_flag));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic tc, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_host <= '{we: 1'b1, tc: tc, addr: a, data: d};
    @(posedge i_sys_clk);
    i_host.we <= 1'b0;
    if (!tc) mdl[a] = d;
  endtask

  task automatic cw(input string nm, input logic tc, input logic [7:0] a, input int ex);
    @(posedge i_sys_clk);
    i_host <= '{we: 1'b0, tc: tc, addr: a, data: 16'h0000};
    @(posedge i_sys_clk);
    #1;
    chk(nm, ex, {16'h0000, o_host_rdata});
  endtask

  function automatic bscc_pkg::bscc_req_t mk(input bscc_pkg::bscc_op_t op,
      input bscc_pkg::bscc_area_t sa, input int sad, input bscc_pkg::bscc_area_t da,
      input int dad, input bscc_pkg::bscc_ty_t st, input bscc_pkg::bscc_ty_t dt,
      input int ln, input logic [31:0] k);
    mk = '{op: op, src_area: sa, src_addr: sad[11:0], dst_area: da, dst_addr: dad[11:0],
           src_type: st, dst_type: dt, len: ln[15:0], konst: k};
  endfunction

  // model: first set bit and ones count over the bench copy of memory
  function automatic int srch(input int base, input int st, input int ln);
    for (int i = 0; i < ln; i++) begin
      if (mdl[base + (st + i) / 16][(st + i) % 16] === 1'b1) return i;
    end
    return 65535;
  endfunction

  function automatic int ones(input int base, input int st, input int ln);
    int c;
    c = 0;
    for (int i = 0; i < ln; i++) c += (mdl[base + (st + i) / 16][(st + i) % 16] === 1'b1);
    return c;
  endfunction

  task automatic run(input bscc_pkg::bscc_req_t r, input logic en, input logic ex_err);
    int n;
    @(posedge i_sys_clk);
    i_req       <= r;
    i_rung_en   <= en;
    i_req_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    n = 0;
    // single-cycle ops pulse done right after the take edge
    #1;
    if (en && !ex_err && r.op != bscc_pkg::OP_DEC && r.op != bscc_pkg::OP_TGL) begin
      chk("busy", 32'h1, {31'h0, o_busy});
    end
    while (o_done !== 1'b1 && n < 600) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n >= 600) begin
      err_count++;
      end_of_test();
    end
    chk("err_flag", {31'h0, ex_err}, {31'h0, o_program_execution_error_flag});
    chk("err_led", {31'h0, ex_err}, {31'h0, o_err_led});
    chk("busy_end", 32'h0, {31'h0, o_busy});
    if (ex_err) begin
      @(posedge i_sys_clk);
      i_err_clr <= 1'b1;
      @(posedge i_sys_clk);
      i_err_clr <= 1'b0;
    end
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_req_valid = 1'b0;
    i_rung_en = 1'b0;
    i_req = '0;
    i_err_clr = 1'b0;
    i_host = '0;
    err_count = 0;
    checked = 0;
    s = $urandom(5921);
    repeat (6) @(posedge i_sys_clk);
    chk("rst_outs", 32'h0, {28'h0, o_busy, o_done, o_program_execution_error_flag, o_err_led});
    i_rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      wr(1'b0, i[7:0], 16'($urandom) & 16'($urandom) & 16'($urandom));
      wr(1'b0, 8'hA0 + i[7:0], 16'($urandom) & 16'($urandom));
    end
    // search from random starts in both areas
    for (int j = 0; j < 6; j++) begin
      s = $urandom_range(40, 0);
      run(mk(bscc_pkg::OP_ENC, j[0] ? DA : RL, s, DA, 320, TW, TW, 64, 0), 1'b1, 1'b0);
      cw("enc_res", 1'b0, 8'hB4, srch(j[0] ? 160 : 0, s, 64));
    end
    wr(1'b0, 8'h0A, 16'h0000);
    wr(1'b0, 8'h0B, 16'h0000);
    run(mk(bscc_pkg::OP_ENC, RL, 160, DA, 320, TW, TW, 32, 0), 1'b1, 1'b0);
    cw("enc_none", 1'b0, 8'hB4, 65535);
    wr(1'b0, 8'hB4, 16'h5A5A);
    run(mk(bscc_pkg::OP_ENC, RL, 0, DA, 320, TW, TW, 64, 0), 1'b0, 1'b0);
    cw("enc_off", 1'b0, 8'hB4, 16'h5A5A);
    // decode at an inner and the top offset
    for (int j = 0; j < 2; j++) begin
      s = j ? 255 : 39;
      t = 480 + s;
      wr(1'b0, 8'(160 + t / 16), 16'h0000);
      run(mk(bscc_pkg::OP_DEC, KC, 0, DA, 480, TW, TW, 1, s), 1'b1, 1'b0);
      cw("dec_bit", 1'b0, 8'(160 + t / 16), 1 << (t % 16));
    end
    run(mk(bscc_pkg::OP_CNT, DA, 0, DA, 320, TW, TW, 60, 0), 1'b1, 1'b0);
    cw("cnt_60", 1'b0, 8'hB4, ones(160, 0, 60));
    s = $urandom_range(200, 0);
    run(mk(bscc_pkg::OP_CNT, RL, s, DA, 320, TW, TW, 256, 0), 1'b1, 1'b0);
    cw("cnt_256", 1'b0, 8'hB4, ones(0, s, 256));
    // toggle on consecutive scans, then with the enable off
    wr(1'b0, 8'h28, 16'h0000);
    for (int j = 0; j < 4; j++) begin
      run(mk(bscc_pkg::OP_TGL, RL, 0, RL, 645, TW, TW, 1, 0), j < 3, 1'b0);
      cw("tgl_bit", 1'b0, 8'h28, (j == 1) ? 0 : 32);
    end
    // conversions from constants, data and a timer into data words from 50, then a constant into a timer preset
    run(mk(bscc_pkg::OP_CVT, KC, 0, DA, 800, TW, TW, 1, 32'h1234), 1'b1, 1'b0);
    cw("cvt_ww", 1'b0, 8'hD2, 16'h1234);
    run(mk(bscc_pkg::OP_CVT, KC, 0, DA, 800, TD, TW, 1, 32'hFFFFFFFF), 1'b1, 1'b0);
    cw("cvt_sat_hi", 1'b0, 8'hD2, 65535);
    run(mk(bscc_pkg::OP_CVT, KC, 0, DA, 800, bscc_pkg::TY_I, TW, 1, 32'h8000), 1'b1, 1'b0);
    cw("cvt_sat_lo", 1'b0, 8'hD2, 0);
    run(mk(bscc_pkg::OP_CVT, KC, 0, DA, 800, TF, TW, 1, 32'h40600000), 1'b1, 1'b0);
    cw("cvt_trunc", 1'b0, 8'hD2, 3);
    run(mk(bscc_pkg::OP_CVT, KC, 0, DA, 800, TF, TF, 1, 32'h40600000), 1'b1, 1'b0);
    cw("cvt_ff_hi", 1'b0, 8'hD2, 16'h4060);
    cw("cvt_ff_lo", 1'b0, 8'hD3, 16'h0000);
    run(mk(bscc_pkg::OP_CVT, DA, 0, DA, 832, TD, TD, 3, 0), 1'b1, 1'b0);
    for (int i = 0; i < 6; i++) cw("cvt_rep", 1'b0, 8'hD4 + i[7:0], mdl[160 + i]);
    wr(1'b1, 8'h03, 16'd777);
    run(mk(bscc_pkg::OP_CVT, bscc_pkg::AR_TC, 3, DA, 800, TW, TW, 1, 0), 1'b1, 1'b0);
    cw("tmr_src", 1'b0, 8'hD2, 777);
    run(mk(bscc_pkg::OP_CVT, KC, 0, bscc_pkg::AR_TC, 4, TD, TW, 1, 32'h12345), 1'b1, 1'b0);
    cw("tmr_preset", 1'b1, 8'h04, 65535);
    // refused requests
    q.push_back(mk(bscc_pkg::OP_ENC, RL, 0, DA, 320, TW, TW, 0, 0));
    q.push_back(mk(bscc_pkg::OP_ENC, RL, 0, DA, 320, TW, TW, 257, 0));
    q.push_back(mk(bscc_pkg::OP_ENC, RL, 2559, DA, 320, TW, TW, 2, 0));
    q.push_back(mk(bscc_pkg::OP_DEC, KC, 0, DA, 480, TW, TW, 1, 256));
    q.push_back(mk(bscc_pkg::OP_DEC, KC, 0, DA, 1520, TW, TW, 1, 100));
    q.push_back(mk(bscc_pkg::OP_CNT, DA, 0, DA, 320, TW, TW, 257, 0));
    q.push_back(mk(bscc_pkg::OP_CNT, RL, 2500, DA, 320, TW, TW, 100, 0));
    q.push_back(mk(bscc_pkg::OP_CVT, KC, 0, DA, 320, TW, TW, 100, 5));
    q.push_back(mk(bscc_pkg::OP_CVT, KC, 0, DA, 320, TW, TW, 0, 5));
    q.push_back(mk(bscc_pkg::OP_CVT, KC, 0, DA, 320, TF, TW, 1, 32'h7F800000));
    q.push_back(mk(bscc_pkg::OP_CVT, KC, 0, RL, 0, TF, TF, 1, 32'h40600000));
    q.push_back(mk(bscc_pkg::OP_CVT, KC, 0, bscc_pkg::AR_SPEC, 0, TW, TW, 1, 5));
    q.push_back(mk(bscc_pkg::OP_CVT, KC, 0, RL, 2544, TW, TW, 1, 5));
    wr(1'b0, 8'hB4, 16'h5A5A);
    foreach (q[i]) run(q[i], 1'b1, 1'b1);
    cw("no_write", 1'b0, 8'hB4, 16'h5A5A);
    cw("relay_kept", 1'b0, 8'h00, mdl[0]);
    end_of_test();
  end
endmodule // bscc_unit_tb
`default_nettype wire
